// ===== hw/fplg_pkg.sv
package fplg_pkg;

    // ****************************************
    // Widths and block geometry
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FUSE_W = 8;
    // Flash sections are counted in 256-byte blocks
    localparam int BLK_SHIFT = 8;

    // ****************************************
    // Fuse offsets, reset values and keys
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_APP_CODE_END = 16'h0007;
    localparam logic [ADDR_W-1:0] OFF_BOOT_END = 16'h0008;
    localparam logic [ADDR_W-1:0] OFF_LOCK_KEY = 16'h000A;
    localparam logic [FUSE_W-1:0] RST_APP_CODE_END = 8'h00;
    localparam logic [FUSE_W-1:0] RST_BOOT_END = 8'h00;
    localparam logic [FUSE_W-1:0] RST_LOCK_KEY = 8'hC5;
    localparam logic [FUSE_W-1:0] LOCK_KEY_OPEN = 8'hC5;
    localparam logic [FUSE_W-1:0] SEC_FUSE_NONE = 8'h00;

    // ****************************************
    // Garbage source for refused reads
    // ****************************************
    localparam logic [DATA_W-1:0] LFSR_SEED = 8'hA5;
    localparam logic [DATA_W-1:0] LFSR_TAPS = 8'hB8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        SP_SRAM,
        SP_REG,
        SP_FLASH,
        SP_EEPROM,
        SP_USER_ROW_B,
        SP_SIGNATURE_ROW,
        SP_FUSE,
        SP_DBG_CS,
        SP_ASYNC_SYS_IFACE
    } fplg_space_t;

    typedef enum logic [1:0] {
        SEC_BOOT,
        SEC_APP_CODE_SECTION,
        SEC_APP_DATA_SECTION
    } fplg_section_t;

    typedef enum {
        ST_RUN,
        ST_ERASE
    } fplg_state_t;

endpackage : fplg_pkg

// ===== hw/fplg_sec_class.sv
`timescale 1ns/10ps
`default_nettype none

module fplg_sec_class
    import fplg_pkg::*;
(
    input wire logic [fplg_pkg::FUSE_W-1:0] boot_end_a,
    input wire logic [fplg_pkg::FUSE_W-1:0] app_code_end,
    input wire logic [fplg_pkg::ADDR_W-1:0] addr,
    output var fplg_pkg::fplg_section_t section
);
    import fplg_pkg::*;

    logic [ADDR_W-1:0] boot_lim;
    logic [ADDR_W-1:0] app_lim;

    // ****************************************
    // Section limits in bytes
    // ****************************************
    assign boot_lim = ADDR_W'(boot_end_a) << BLK_SHIFT;
    assign app_lim = ADDR_W'(app_code_end) << BLK_SHIFT;

    always_comb begin
        if (boot_end_a == SEC_FUSE_NONE) begin
            section = SEC_BOOT;
        end else if (addr < boot_lim) begin
            section = SEC_BOOT;
        end else if (app_code_end == SEC_FUSE_NONE) begin
            section = SEC_APP_CODE_SECTION;
        end else if (addr < app_lim) begin
            section = SEC_APP_CODE_SECTION;
        end else begin
            section = SEC_APP_DATA_SECTION;
        end
    end

endmodule : fplg_sec_class

`default_nettype wire

// ===== hw/fplg_guard.sv
`timescale 1ns/10ps
`default_nettype none

module fplg_guard
    import fplg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [fplg_pkg::FUSE_W-1:0] app_code_end_fuse,
    input wire logic [fplg_pkg::FUSE_W-1:0] boot_end_fuse,
    input wire logic [fplg_pkg::FUSE_W-1:0] lock_key_fuse,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire fplg_pkg::fplg_space_t cpu_space,
    input wire logic [fplg_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [fplg_pkg::DATA_W-1:0] cpu_mem_rdata,
    output logic cpu_grant,
    output logic cpu_rvalid,
    output logic [fplg_pkg::DATA_W-1:0] cpu_rdata,
    output var fplg_pkg::fplg_section_t cpu_section,
    input wire logic dbg_req,
    input wire logic dbg_we,
    input wire logic dbg_fuse_wr_cmd,
    input wire fplg_pkg::fplg_space_t dbg_space,
    input wire logic [fplg_pkg::ADDR_W-1:0] dbg_addr,
    input wire logic [fplg_pkg::DATA_W-1:0] dbg_mem_rdata,
    output logic dbg_grant,
    output logic dbg_rvalid,
    output logic [fplg_pkg::DATA_W-1:0] dbg_rdata,
    output var fplg_pkg::fplg_section_t dbg_section,
    input wire logic full_erase_cmd,
    input wire logic erase_done,
    output logic erase_start,
    output logic erase_busy,
    output logic dev_locked
);
    import fplg_pkg::*;

    fplg_state_t state_q;
    logic loaded_q;
    logic lock_q;
    logic [FUSE_W-1:0] app_end_q;
    logic [FUSE_W-1:0] boot_end_q;
    logic [FUSE_W-1:0] key_q;
    logic [DATA_W-1:0] lfsr_q;
    logic erase_start_q;
    logic cpu_rvalid_q;
    logic dbg_rvalid_q;
    logic [DATA_W-1:0] cpu_rdata_q;
    logic [DATA_W-1:0] dbg_rdata_q;
    logic cpu_ok;
    logic dbg_ok;
    logic erase_fin;

    // ****************************************
    // Access policy
    // ****************************************
    function automatic logic cpu_ok_f(fplg_space_t sp, logic we);
        logic r;
        r = 1'b1;
        if (sp == SP_DBG_CS || sp == SP_ASYNC_SYS_IFACE) begin
            r = 1'b0;
        end else if (we && (sp == SP_SIGNATURE_ROW || sp == SP_FUSE)) begin
            r = 1'b0;
        end
        return r;
    endfunction : cpu_ok_f

    // Debug own space stays reachable so a locked part can still be erased
    function automatic logic dbg_ok_f(logic locked, logic busy,
                                      fplg_space_t sp, logic we,
                                      logic fcmd);
        logic r;
        r = 1'b0;
        if (sp == SP_DBG_CS || sp == SP_ASYNC_SYS_IFACE) begin
            r = 1'b1;
        end else if (busy) begin
            r = 1'b0;
        end else if (!locked) begin
            r = !(we && sp == SP_SIGNATURE_ROW);
        end else begin
            r = we && fcmd && sp == SP_USER_ROW_B;
        end
        return r;
    endfunction : dbg_ok_f

    // Latched fuse copies shadow the live array, so readback matches policy
    function automatic logic [DATA_W-1:0] rd_f(fplg_space_t sp,
                                              logic [ADDR_W-1:0] a,
                                              logic [DATA_W-1:0] mem);
        logic [DATA_W-1:0] r;
        r = mem;
        if (sp == SP_FUSE && a == OFF_APP_CODE_END) begin
            r = app_end_q;
        end else if (sp == SP_FUSE && a == OFF_BOOT_END) begin
            r = boot_end_q;
        end else if (sp == SP_FUSE && a == OFF_LOCK_KEY) begin
            r = key_q;
        end
        return r;
    endfunction : rd_f

    assign cpu_ok = cpu_ok_f(cpu_space, cpu_we);
    assign dbg_ok = dbg_ok_f(lock_q, erase_busy, dbg_space, dbg_we,
                             dbg_fuse_wr_cmd);
    assign cpu_grant = ce && cpu_req && cpu_ok;
    assign dbg_grant = ce && dbg_req && dbg_ok;
    assign erase_fin = ce && state_q == ST_ERASE && erase_done;

    // ****************************************
    // Fuse capture and lock state
    // ****************************************
    // Fuses are caught on the first enabled edge after reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded_q <= 1'b0;
            lock_q <= 1'b1;
            app_end_q <= RST_APP_CODE_END;
            boot_end_q <= RST_BOOT_END;
            key_q <= RST_LOCK_KEY;
        end else if (ce) begin
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                app_end_q <= app_code_end_fuse;
                boot_end_q <= boot_end_fuse;
                key_q <= lock_key_fuse;
                lock_q <= lock_key_fuse != LOCK_KEY_OPEN;
            end else if (erase_fin) begin
                lock_q <= 1'b0;
                app_end_q <= RST_APP_CODE_END;
                boot_end_q <= RST_BOOT_END;
                key_q <= RST_LOCK_KEY;
            end
        end
    end

    // ****************************************
    // Full erase sequencer
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_RUN;
            erase_start_q <= 1'b0;
        end else if (ce) begin
            erase_start_q <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (loaded_q && full_erase_cmd) begin
                        state_q <= ST_ERASE;
                        erase_start_q <= 1'b1;
                    end
                end
                ST_ERASE: begin
                    if (erase_done) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    assign erase_start = erase_start_q;
    assign erase_busy = state_q == ST_ERASE;
    assign dev_locked = lock_q;

    // ****************************************
    // Read return path
    // ****************************************
    // A free-running LFSR keeps refused data from being a known constant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lfsr_q <= LFSR_SEED;
        end else if (ce) begin
            lfsr_q <= {lfsr_q[DATA_W-2:0], ^(lfsr_q & LFSR_TAPS)};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rvalid_q <= 1'b0;
            cpu_rdata_q <= '0;
        end else if (ce) begin
            cpu_rvalid_q <= cpu_req && !cpu_we;
            if (cpu_req && !cpu_we) begin
                cpu_rdata_q <= cpu_ok ?
                    rd_f(cpu_space, cpu_addr, cpu_mem_rdata) : lfsr_q;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dbg_rvalid_q <= 1'b0;
            dbg_rdata_q <= '0;
        end else if (ce) begin
            dbg_rvalid_q <= dbg_req && !dbg_we;
            if (dbg_req && !dbg_we) begin
                dbg_rdata_q <= dbg_ok ?
                    rd_f(dbg_space, dbg_addr, dbg_mem_rdata) : lfsr_q;
            end
        end
    end

    assign cpu_rvalid = cpu_rvalid_q;
    assign cpu_rdata = cpu_rdata_q;
    assign dbg_rvalid = dbg_rvalid_q;
    assign dbg_rdata = dbg_rdata_q;

    // ****************************************
    // Flash section classification
    // ****************************************
    fplg_sec_class u_cpu_sec (
        .boot_end_a(boot_end_q),
        .app_code_end(app_end_q),
        .addr(cpu_addr),
        .section(cpu_section)
    );

    fplg_sec_class u_dbg_sec (
        .boot_end_a(boot_end_q),
        .app_code_end(app_end_q),
        .addr(dbg_addr),
        .section(dbg_section)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence erase_cmd_s;
        ce && state_q == ST_RUN && loaded_q && full_erase_cmd;
    endsequence

    sequence erase_armed_s;
        erase_start && erase_busy;
    endsequence

    locked_dbg_deny_a: assert property (
        dev_locked && dbg_req && (dbg_space == SP_SRAM ||
        dbg_space == SP_FLASH || dbg_space == SP_FUSE) |-> !dbg_grant)
        else $error("locked debug access to memory granted");

    locked_dbg_own_a: assert property (
        ce && dev_locked && dbg_req && dbg_space == SP_DBG_CS |-> dbg_grant)
        else $error("locked debug own space refused");

    cpu_unrestricted_a: assert property (
        ce && cpu_req && !cpu_we && dev_locked &&
        cpu_space == SP_SIGNATURE_ROW |-> cpu_grant)
        else $error("locked CPU read of signature row refused");

    cpu_no_sig_wr_a: assert property (
        cpu_req && cpu_we && (cpu_space == SP_SIGNATURE_ROW ||
        cpu_space == SP_FUSE) |-> !cpu_grant)
        else $error("CPU write to signature row or fuse granted");

    user_row_blind_a: assert property (
        ce && dev_locked && !erase_busy && dbg_req &&
        dbg_space == SP_USER_ROW_B |-> dbg_grant == (dbg_we &&
        dbg_fuse_wr_cmd))
        else $error("locked user row access policy wrong");

    denied_read_a: assert property (
        ce && dbg_req && !dbg_we && !dbg_grant |=>
        dbg_rvalid && dbg_rdata == $past(lfsr_q))
        else $error("refused read did not return garbage");

    key_capture_a: assert property (
        $rose(loaded_q) |-> dev_locked ==
        ($past(lock_key_fuse) != LOCK_KEY_OPEN))
        else $error("lock state does not follow key");

    lock_hold_a: assert property (
        loaded_q && !erase_fin |=> $stable(dev_locked))
        else $error("lock state changed without erase");

    erase_unlock_a: assert property (
        erase_cmd_s ##1 erase_armed_s ##[0:300] erase_fin |=>
        !dev_locked && !erase_busy)
        else $error("full erase did not unlock");

    boot_whole_a: assert property (
        boot_end_q == SEC_FUSE_NONE |-> cpu_section == SEC_BOOT)
        else $error("zero boot end not whole boot");

endmodule : fplg_guard

`default_nettype wire

// ===== bench/fplg_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module fplg_mem_model #(
    parameter int ERASE_LAT = 4
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [fplg_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [fplg_pkg::ADDR_W-1:0] dbg_addr,
    input wire logic erase_start,
    output logic [fplg_pkg::DATA_W-1:0] cpu_mem_rdata,
    output logic [fplg_pkg::DATA_W-1:0] dbg_mem_rdata,
    output logic erase_done
);
    import fplg_pkg::*;

    logic [7:0] cnt_q;

    // ****************************************
    // Memory contents and erase sequencer
    // ****************************************
    // Address 0x3C holds 0x00, a value the garbage source never makes
    assign cpu_mem_rdata = cpu_addr[7:0] ^ 8'h3C;
    assign dbg_mem_rdata = dbg_addr[7:0] ^ 8'h3C;

    // Erase completes ERASE_LAT cycles after erase_start is taken; the byte contents never change
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            erase_done <= 1'b0;
        end else begin
            erase_done <= (cnt_q == 8'h01);
            if (erase_start) begin
                cnt_q <= ERASE_LAT[7:0];
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : fplg_mem_model

`default_nettype wire

// ===== bench/tb_flash_partition_lock_guard.sv
`timescale 1ns/10ps
`default_nettype none

module tb_flash_partition_lock_guard;
    import fplg_pkg::*;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] f_app = 8'h00;
    logic [7:0] f_boot = 8'h00;
    logic [7:0] f_key = 8'hC5;
    logic cpu_req = 1'b0;
    logic dbg_req = 1'b0;
    logic we_r = 1'b0;
    logic fw_r = 1'b0;
    logic full_erase_cmd = 1'b0;
    fplg_space_t sp_r = SP_SRAM;
    logic [15:0] ad_r = 16'h0000;
    logic [7:0] cpu_md, dbg_md, cpu_rdata, dbg_rdata;
    logic cpu_grant, cpu_rvalid, dbg_grant, dbg_rvalid;
    logic erase_done, erase_start, erase_busy, dev_locked;
    fplg_section_t cpu_section, dbg_section;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    fplg_guard dut (.clk(clk), .nrst(nrst), .ce(ce),
        .app_code_end_fuse(f_app), .boot_end_fuse(f_boot),
        .lock_key_fuse(f_key), .cpu_req(cpu_req), .cpu_we(we_r),
        .cpu_space(sp_r), .cpu_addr(ad_r), .cpu_mem_rdata(cpu_md),
        .cpu_grant(cpu_grant), .cpu_rvalid(cpu_rvalid),
        .cpu_rdata(cpu_rdata), .cpu_section(cpu_section),
        .dbg_req(dbg_req), .dbg_we(we_r), .dbg_fuse_wr_cmd(fw_r),
        .dbg_space(sp_r), .dbg_addr(ad_r), .dbg_mem_rdata(dbg_md),
        .dbg_grant(dbg_grant), .dbg_rvalid(dbg_rvalid),
        .dbg_rdata(dbg_rdata), .dbg_section(dbg_section),
        .full_erase_cmd(full_erase_cmd), .erase_done(erase_done),
        .erase_start(erase_start), .erase_busy(erase_busy),
        .dev_locked(dev_locked));

    fplg_mem_model #(.ERASE_LAT(4)) mem (.clk(clk), .nrst(nrst),
        .cpu_addr(ad_r), .dbg_addr(ad_r), .erase_start(erase_start),
        .cpu_mem_rdata(cpu_md), .dbg_mem_rdata(dbg_md),
        .erase_done(erase_done));

    // ****************************************
    // Checking and access tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // Generous ceiling; the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // Garbage may be anything except the true memory byte
    task automatic chk_ne(input logic [7:0] got, input logic [7:0] bad);
        num_checks++;
        if (got === bad) begin
            errors++;
            $display("wrong value at %0t: got %h expected not %h",
                     $time, got, bad);
        end
    endtask : chk_ne

    function automatic logic allow(input logic dbg, input logic lk,
                                   input logic we, input fplg_space_t sp,
                                   input logic fw);
        if (!dbg) begin
            return !(sp inside {SP_DBG_CS, SP_ASYNC_SYS_IFACE}) &&
                   !(we && sp inside {SP_SIGNATURE_ROW, SP_FUSE});
        end
        if (sp inside {SP_DBG_CS, SP_ASYNC_SYS_IFACE}) begin
            return 1'b1;
        end
        if (!lk) begin
            return !(we && sp == SP_SIGNATURE_ROW);
        end
        return we && fw && sp == SP_USER_ROW_B;
    endfunction : allow

    task automatic do_reset(input logic [7:0] a, input logic [7:0] b,
                            input logic [7:0] k);
        f_app = a;
        f_boot = b;
        f_key = k;
        nrst = 1'b0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // One access of one cycle; request stays up for a following access
    task automatic acc(input logic dbg, input logic we,
                       input fplg_space_t sp, input logic [15:0] ad,
                       input logic fw, output logic g, output logic v,
                       output logic [7:0] d);
        cpu_req = !dbg;
        dbg_req = dbg;
        we_r = we;
        sp_r = sp;
        ad_r = ad;
        fw_r = fw;
        #5;
        g = dbg ? dbg_grant : cpu_grant;
        @(posedge clk);
        #1;
        v = dbg ? dbg_rvalid : cpu_rvalid;
        d = dbg ? dbg_rdata : cpu_rdata;
    endtask : acc

    task automatic idle();
        cpu_req = 1'b0;
        dbg_req = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle

    task automatic sweep(input logic lk);
        logic g, v, e;
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 9; s++) begin
                for (int w = 0; w < 2; w++) begin
                    for (int f = 0; f <= p; f++) begin
                        e = allow(p[0], lk, w[0], fplg_space_t'(s), f[0]);
                        acc(p[0], w[0], fplg_space_t'(s), 16'h003C, f[0],
                            g, v, d);
                        chk(g, e);
                        chk(v, !w[0]);
                        if (!w[0] && e) chk(d, 8'h00);
                        if (!w[0] && !e) chk_ne(d, 8'h00);
                    end
                end
            end
        end
        idle();
    endtask : sweep

    task automatic rdf(input logic [15:0] off, input logic [7:0] exp);
        logic g, v;
        logic [7:0] d;
        acc(1'b0, 1'b0, SP_FUSE, off, 1'b0, g, v, d);
        chk(d, exp);
        idle();
    endtask : rdf

    task automatic sec(input logic [15:0] ad, input fplg_section_t e);
        ad_r = ad;
        #5;
        chk(cpu_section, e);
        chk(dbg_section, e);
        @(posedge clk);
        #1;
    endtask : sec

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic g, v;
        logic [7:0] d;
        do_reset(8'h10, 8'h04, LOCK_KEY_OPEN);
        chk(dev_locked, 1'b0);
        sec(16'h03FF, SEC_BOOT);
        sec(16'h0400, SEC_APP_CODE_SECTION);
        sec(16'h0FFF, SEC_APP_CODE_SECTION);
        sec(16'h1000, SEC_APP_DATA_SECTION);
        rdf(OFF_APP_CODE_END, 8'h10);
        rdf(OFF_BOOT_END, 8'h04);
        rdf(OFF_LOCK_KEY, 8'hC5);
        // Enable low must hold grant low and freeze read pulse and read data
        ce = 1'b0;
        acc(1'b0, 1'b0, SP_SRAM, 16'h003C, 1'b0, g, v, d);
        chk(g, 1'b0);
        chk(v, 1'b0);
        chk(d, 8'hC5);
        ce = 1'b1;
        sweep(1'b0);
        do_reset(8'h00, 8'h04, 8'h00);
        chk(dev_locked, 1'b1);
        f_key = LOCK_KEY_OPEN;
        sec(16'h03FF, SEC_BOOT);
        sec(16'h0400, SEC_APP_CODE_SECTION);
        sec(16'hFFFF, SEC_APP_CODE_SECTION);
        sweep(1'b1);
        chk(dev_locked, 1'b1);
        do_reset(8'h20, 8'h00, 8'hC4);
        chk(dev_locked, 1'b1);
        sec(16'h0000, SEC_BOOT);
        sec(16'hFFFF, SEC_BOOT);
        full_erase_cmd = 1'b1;
        @(posedge clk);
        #1;
        full_erase_cmd = 1'b0;
        chk(erase_start, 1'b1);
        chk(erase_busy, 1'b1);
        @(posedge clk);
        #1;
        chk(erase_start, 1'b0);
        repeat (20) begin
            if (erase_busy === 1'b1) begin
                @(posedge clk);
                #1;
            end
        end
        chk(erase_busy, 1'b0);
        chk(dev_locked, 1'b0);
        rdf(OFF_APP_CODE_END, RST_APP_CODE_END);
        rdf(OFF_LOCK_KEY, RST_LOCK_KEY);
        sweep(1'b0);
        end_of_test();
    end
endmodule : tb_flash_partition_lock_guard

`default_nettype wire
